/* logic/strb_pkg.sv */
// Constants, register map and decode for the sampling trim register bank.
// Assumes a byte-wide serial register port with fifteen-bit addresses.
package strb_pkg;

  // Serial frame layout: read flag, address, data byte
  localparam int ADDR_W = 15;
  localparam int BYTE_W = 8;
  localparam int FRAME_LEN = 24;
  localparam int ADDR_DONE = 16;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] ADDR_LAST = 5'h0f;
  localparam int READ_FLAG_BIT = 14;

  // Register offsets
  localparam logic [14:0] ADDR_TT_A_DUAL = 15'h0310;
  localparam logic [14:0] ADDR_TT_B_DUAL = 15'h0313;
  localparam logic [14:0] ADDR_TT_A_SIN_A = 15'h0314;
  localparam logic [14:0] ADDR_TT_B_SIN_A = 15'h0315;
  localparam logic [14:0] ADDR_TT_A_SIN_B = 15'h031a;
  localparam logic [14:0] ADDR_TT_B_SIN_B = 15'h031b;
  localparam logic [14:0] ADDR_OT_A_DUAL_A = 15'h0344;
  localparam logic [14:0] ADDR_OT_A_DUAL_B = 15'h0346;

  // Storage slots, also the fuse word order
  localparam int NUM_TRIM = 8;
  localparam int IDX_W = 3;
  localparam logic [2:0] IDX_TT_A_DUAL = 3'h0;
  localparam logic [2:0] IDX_TT_B_DUAL = 3'h1;
  localparam logic [2:0] IDX_TT_A_SIN_A = 3'h2;
  localparam logic [2:0] IDX_TT_B_SIN_A = 3'h3;
  localparam logic [2:0] IDX_TT_A_SIN_B = 3'h4;
  localparam logic [2:0] IDX_TT_B_SIN_B = 3'h5;
  localparam logic [2:0] IDX_OT_A_DUAL_A = 3'h6;
  localparam logic [2:0] IDX_OT_A_DUAL_B = 3'h7;
  localparam logic [2:0] IDX_LAST = 3'h7;

  // Field widths and reset value
  localparam int WORD_W = 16;
  localparam int TIMING_W = 8;
  localparam int OFFSET_W = 12;
  localparam logic [15:0] TRIM_RESET = 16'h0000;

  typedef struct packed {
    logic hit;
    logic hi;
    logic [2:0] idx;
  } strb_decode_t;

  // Map a byte address to a slot and byte lane
  function automatic strb_decode_t strb_decode(input logic [14:0] addr);
    strb_decode_t d;
    d = '{hit: 1'b1, hi: 1'b0, idx: IDX_TT_A_DUAL};
    case (addr)
      ADDR_TT_A_DUAL: d.idx = IDX_TT_A_DUAL;
      ADDR_TT_B_DUAL: d.idx = IDX_TT_B_DUAL;
      ADDR_TT_A_SIN_A: d.idx = IDX_TT_A_SIN_A;
      ADDR_TT_B_SIN_A: d.idx = IDX_TT_B_SIN_A;
      ADDR_TT_A_SIN_B: d.idx = IDX_TT_A_SIN_B;
      ADDR_TT_B_SIN_B: d.idx = IDX_TT_B_SIN_B;
      ADDR_OT_A_DUAL_A: d.idx = IDX_OT_A_DUAL_A;
      ADDR_OT_A_DUAL_A + 15'h0001: begin
        d.idx = IDX_OT_A_DUAL_A;
        d.hi = 1'b1;
      end
      ADDR_OT_A_DUAL_B: d.idx = IDX_OT_A_DUAL_B;
      ADDR_OT_A_DUAL_B + 15'h0001: begin
        d.idx = IDX_OT_A_DUAL_B;
        d.hi = 1'b1;
      end
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction : strb_decode

endpackage : strb_pkg

/* logic/strb_spi_port.sv */
// Serial register port: three-wire frame slave sampled on the system clock.
// Assumes the serial clock is at most an eighth of clk; pins are asynchronous.
`timescale 1ns/10ps
module strb_spi_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Register side
  output logic [strb_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [strb_pkg::BYTE_W-1:0] rd_data,
  output logic wr_en,
  output logic [strb_pkg::ADDR_W-1:0] wr_addr,
  output logic [strb_pkg::BYTE_W-1:0] wr_data
);
  import strb_pkg::*;

  logic [1:0] sclk_sync, cs_sync, sdi_sync;
  logic sclk_prev;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [23:0] shift_q, next_shift_q;
  logic [7:0] out_q, next_out_q;
  logic sdo_q, next_sdo_q, oe_q, next_oe_q, wr_q, next_wr_q, load_q, next_load_q;
  logic rise, fall;

  // Two-stage synchronisers for the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_sync <= 2'h0;
      cs_sync <= 2'h3;
      sdi_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk};
      cs_sync <= {cs_sync[0], cs_n};
      sdi_sync <= {sdi_sync[0], sdi};
      sclk_prev <= sclk_sync[1];
    end
  end

  assign rise = sclk_sync[1] & ~sclk_prev;
  assign fall = ~sclk_sync[1] & sclk_prev;

  // Frame engine: shift in, launch read data on falling edges
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shift_q = shift_q;
    next_out_q = out_q;
    next_sdo_q = sdo_q;
    next_oe_q = oe_q;
    next_wr_q = 1'b0;
    next_load_q = 1'b0;
    if (cs_sync[1]) begin
      next_bit_cnt = 5'h00;
      next_oe_q = 1'b0;
      next_sdo_q = 1'b0;
    end else begin
      if (rise && bit_cnt <= FRAME_LAST) begin
        next_shift_q = {shift_q[22:0], sdi_sync[1]};
        next_bit_cnt = bit_cnt + 5'h01;
        if (bit_cnt == ADDR_LAST) begin
          next_load_q = shift_q[READ_FLAG_BIT];
        end
        if (bit_cnt == FRAME_LAST && !shift_q[22]) begin
          next_wr_q = 1'b1;
        end
      end
      if (load_q) begin
        next_out_q = rd_data;
        next_oe_q = 1'b1;
      end
      if (fall && oe_q && bit_cnt <= FRAME_LAST) begin
        next_sdo_q = out_q[7];
        next_out_q = {out_q[6:0], 1'b0};
      end
    end
  end

  // Frame engine registers
  always_ff @(posedge clk) begin
    if (rst) begin
      bit_cnt <= 5'h00;
      shift_q <= 24'h000000;
      out_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift_q <= next_shift_q;
      out_q <= next_out_q;
      sdo_q <= next_sdo_q;
      oe_q <= next_oe_q;
      wr_q <= next_wr_q;
      load_q <= next_load_q;
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe = oe_q;
  assign rd_addr = shift_q[14:0];
  assign wr_en = wr_q;
  assign wr_addr = shift_q[22:8];
  assign wr_data = shift_q[7:0];

endmodule : strb_spi_port

/* logic/strb_fuse_loader.sv */
// Fuse loader: reads every trim default from fuse storage after reset.
// Assumes fuse data is valid on the cycle after a read strobe.
`timescale 1ns/10ps
module strb_fuse_loader (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fuse storage
  output logic fuse_rd,
  output logic [strb_pkg::IDX_W-1:0] fuse_addr,
  input wire logic [strb_pkg::WORD_W-1:0] fuse_data,
  // Load strobe toward the bank
  output logic load_en,
  output logic [strb_pkg::IDX_W-1:0] load_idx,
  output logic [strb_pkg::WORD_W-1:0] load_data,
  output logic done
);
  import strb_pkg::*;

  typedef enum logic [1:0] {FL_READ, FL_WAIT, FL_DONE} strb_fl_state_t;
  strb_fl_state_t state, next_state;
  logic [2:0] idx, next_idx;

  // Walk the slots once, one read and one capture each
  always_comb begin
    next_state = state;
    next_idx = idx;
    case (state)
      FL_READ: next_state = FL_WAIT;
      FL_WAIT: begin
        if (idx == IDX_LAST) begin
          next_state = FL_DONE;
        end else begin
          next_idx = idx + 3'h1;
          next_state = FL_READ;
        end
      end
      FL_DONE: next_state = FL_DONE;
      default: next_state = FL_DONE;
    endcase
  end

  // Loader registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= FL_READ;
      idx <= 3'h0;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  assign fuse_rd = (state == FL_READ);
  assign fuse_addr = idx;
  assign load_en = (state == FL_WAIT);
  assign load_idx = idx;
  assign load_data = fuse_data;
  assign done = (state == FL_DONE);

endmodule : strb_fuse_loader

/* logic/strb_trim_bank.sv */
// Trim register bank: timing and offset trims for a two-core sampling
// converter, reached over the serial register port, loaded from fuses.
// Assumes mode inputs come from logic on clk; serial pins are asynchronous.
`timescale 1ns/10ps
// Function
// - Each eight-bit timing trim moves its core's sampling instant by its stored value.
// - Only the timing trim matching the current core and mode is applied to each core.
// - Every trim defaults to a factory value that software can read back and overwrite.
// - After power-up each trim is loaded from fuse storage instead of staying zero.
// - Core B in dual mode with calibration on takes its timing trim from 0x313.
// - Core A on input A in single mode with calibration on uses the trim at 0x314.
// - Core B on input A in single mode with calibration on uses the trim at 0x315.
// - Core A on input B in single mode with calibration on uses the trim at 0x31A.
// - Core B on input B in single mode with calibration on uses the trim at 0x31B.
// - Core A on input A in dual mode with calibration on gets a twelve-bit offset trim.
// - Core A on input B in dual mode with calibration on takes its offset trim from 0x346.
module strb_trim_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial register port pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Fuse storage
  output logic fuse_rd,
  output logic [strb_pkg::IDX_W-1:0] fuse_addr,
  input wire logic [strb_pkg::WORD_W-1:0] fuse_data,
  // Operating mode
  input wire logic dual_mode,
  input wire logic sample_input_b,
  input wire logic fg_cal_en,
  // Trims applied to the cores
  output logic [strb_pkg::TIMING_W-1:0] core_a_timing_trim,
  output logic [strb_pkg::TIMING_W-1:0] core_b_timing_trim,
  output logic core_timing_trim_valid,
  output logic [strb_pkg::OFFSET_W-1:0] core_a_offset_trim,
  output logic core_a_offset_trim_valid,
  output logic trims_loaded
);
  import strb_pkg::*;

  // Trim storage, one sixteen-bit word per slot
  logic [WORD_W-1:0] trim_q [NUM_TRIM];
  logic [WORD_W-1:0] next_trim [NUM_TRIM];

  // Port and loader wiring
  logic [ADDR_W-1:0] rd_addr;
  logic [BYTE_W-1:0] rd_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [BYTE_W-1:0] wr_data;
  logic load_en;
  logic [IDX_W-1:0] load_idx;
  logic [WORD_W-1:0] load_data;
  logic load_done;
  logic sdo_int;
  logic sdo_oe_int;
  logic fuse_rd_int;
  logic [IDX_W-1:0] fuse_addr_int;
  strb_decode_t rd_dec;
  strb_decode_t wr_dec;

  // Registered outputs
  logic [TIMING_W-1:0] ta_q, next_ta_q;
  logic [TIMING_W-1:0] tb_q, next_tb_q;
  logic tv_q, next_tv_q;
  logic [OFFSET_W-1:0] oa_q, next_oa_q;
  logic ov_q, next_ov_q;
  logic loaded_q;
  logic sdo_q;
  logic sdo_oe_q;
  logic fuse_rd_q;
  logic [IDX_W-1:0] fuse_addr_q;

  // Serial register port
  strb_spi_port u_port (
    .clk(clk),
    .rst(rst),
    .sclk(spi_sclk),
    .cs_n(spi_cs_n),
    .sdi(spi_sdi),
    .sdo(sdo_int),
    .sdo_oe(sdo_oe_int),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // Default loader from fuse storage
  strb_fuse_loader u_loader (
    .clk(clk),
    .rst(rst),
    .fuse_rd(fuse_rd_int),
    .fuse_addr(fuse_addr_int),
    .fuse_data(fuse_data),
    .load_en(load_en),
    .load_idx(load_idx),
    .load_data(load_data),
    .done(load_done)
  );

  // Read decode; unmapped addresses read as zero
  always_comb begin
    rd_dec = strb_decode(rd_addr);
    rd_data = 8'h00;
    if (rd_dec.hit) begin
      if (rd_dec.hi) begin
        rd_data = trim_q[rd_dec.idx][15:8];
      end else begin
        rd_data = trim_q[rd_dec.idx][7:0];
      end
    end
  end

  // Storage update: fuse load first, then software writes
  always_comb begin
    wr_dec = strb_decode(wr_addr);
    for (int i = 0; i < NUM_TRIM; i++) begin
      next_trim[i] = trim_q[i];
    end
    if (load_en) begin
      next_trim[load_idx] = load_data;
    end else if (wr_en && load_done && wr_dec.hit) begin
      if (wr_dec.hi) begin
        next_trim[wr_dec.idx][15:8] = wr_data;
      end else begin
        next_trim[wr_dec.idx][7:0] = wr_data;
      end
    end
  end

  // Storage registers, cleared until the fuse load lands
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_TRIM; i++) begin
        trim_q[i] <= TRIM_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_TRIM; i++) begin
        trim_q[i] <= next_trim[i];
      end
    end
  end

  // Trim selection by core, mode and sampled input
  always_comb begin
    next_ta_q = '0;
    next_tb_q = '0;
    next_tv_q = 1'b0;
    next_oa_q = '0;
    next_ov_q = 1'b0;
    if (fg_cal_en && load_done) begin
      next_tv_q = 1'b1;
      if (dual_mode) begin
        next_ta_q = trim_q[IDX_TT_A_DUAL][TIMING_W-1:0];
        next_tb_q = trim_q[IDX_TT_B_DUAL][TIMING_W-1:0];
        next_ov_q = 1'b1;
        if (sample_input_b) begin
          next_oa_q = trim_q[IDX_OT_A_DUAL_B][OFFSET_W-1:0];
        end else begin
          next_oa_q = trim_q[IDX_OT_A_DUAL_A][OFFSET_W-1:0];
        end
      end else if (sample_input_b) begin
        next_ta_q = trim_q[IDX_TT_A_SIN_B][TIMING_W-1:0];
        next_tb_q = trim_q[IDX_TT_B_SIN_B][TIMING_W-1:0];
      end else begin
        next_ta_q = trim_q[IDX_TT_A_SIN_A][TIMING_W-1:0];
        next_tb_q = trim_q[IDX_TT_B_SIN_A][TIMING_W-1:0];
      end
    end
  end

  // Applied trims toward the sampling delay lines
  always_ff @(posedge clk) begin
    if (rst) begin
      ta_q <= '0;
      tb_q <= '0;
      tv_q <= 1'b0;
      oa_q <= '0;
      ov_q <= 1'b0;
    end else begin
      ta_q <= next_ta_q;
      tb_q <= next_tb_q;
      tv_q <= next_tv_q;
      oa_q <= next_oa_q;
      ov_q <= next_ov_q;
    end
  end

  // Output staging so every port leaves from a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      loaded_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      fuse_rd_q <= 1'b0;
      fuse_addr_q <= '0;
    end else begin
      loaded_q <= load_done;
      sdo_q <= sdo_int;
      sdo_oe_q <= sdo_oe_int;
      fuse_rd_q <= fuse_rd_int;
      fuse_addr_q <= fuse_addr_int;
    end
  end

  // Port drivers
  assign spi_sdo = sdo_q;
  assign spi_sdo_oe = sdo_oe_q;
  assign fuse_rd = fuse_rd_q;
  assign fuse_addr = fuse_addr_q;
  assign core_a_timing_trim = ta_q;
  assign core_b_timing_trim = tb_q;
  assign core_timing_trim_valid = tv_q;
  assign core_a_offset_trim = oa_q;
  assign core_a_offset_trim_valid = ov_q;
  assign trims_loaded = loaded_q;

endmodule : strb_trim_bank

/* sim/strb_trim_bank_asserts.sv */
// Port checker for the trim bank: reset, fuse load order, mode gating.
// Assumes it is bound onto strb_trim_bank and sees only its ports.
`timescale 1ns/10ps
module strb_trim_bank_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic fuse_rd,
  input wire logic [strb_pkg::IDX_W-1:0] fuse_addr,
  input wire logic dual_mode,
  input wire logic fg_cal_en,
  input wire logic [strb_pkg::TIMING_W-1:0] core_a_timing_trim,
  input wire logic [strb_pkg::TIMING_W-1:0] core_b_timing_trim,
  input wire logic core_timing_trim_valid,
  input wire logic [strb_pkg::OFFSET_W-1:0] core_a_offset_trim,
  input wire logic core_a_offset_trim_valid,
  input wire logic trims_loaded
);
  import strb_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Load steps
  sequence s_fuse_pulse;
    fuse_rd ##1 !fuse_rd;
  endsequence
  sequence s_loading;
    !trims_loaded [*8];
  endsequence
  property p_fuse_step;
    fuse_rd && fuse_addr != 3'h7 |-> s_fuse_pulse ##1
      (fuse_rd && fuse_addr == $past(fuse_addr, 2) + 3'h1);
  endproperty
  a_fuse_step: assert property (p_fuse_step) else $error("fuse slot order broken");
  property p_fuse_first;
    $fell(rst) |-> ##[0:2] (fuse_rd && fuse_addr == 3'h0);
  endproperty
  a_fuse_first: assert property (p_fuse_first) else $error("fuse load did not start");
  property p_load_time;
    $fell(rst) |-> s_loading ##[1:20] trims_loaded;
  endproperty
  a_load_time: assert property (p_load_time) else $error("load time wrong");
  property p_loaded_hold;
    trims_loaded |=> trims_loaded;
  endproperty
  a_loaded_hold: assert property (p_loaded_hold) else $error("loaded flag dropped");
  property p_reset_clear;
    $fell(rst) |-> !spi_sdo_oe && !core_timing_trim_valid && core_a_timing_trim == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
  property p_cal_off;
    !fg_cal_en |=> !core_timing_trim_valid && core_a_timing_trim == 8'h00 &&
      core_b_timing_trim == 8'h00;
  endproperty
  a_cal_off: assert property (p_cal_off) else $error("trim applied without cal");
  property p_valid_on;
    fg_cal_en && trims_loaded |=> core_timing_trim_valid;
  endproperty
  a_valid_on: assert property (p_valid_on) else $error("timing valid missing");
  property p_off_valid;
    dual_mode && fg_cal_en && trims_loaded |=> core_a_offset_trim_valid;
  endproperty
  a_off_valid: assert property (p_off_valid) else $error("offset valid missing");
  property p_single_off;
    !dual_mode |=> !core_a_offset_trim_valid && core_a_offset_trim == 12'h000;
  endproperty
  a_single_off: assert property (p_single_off) else $error("offset in single mode");
  property p_sdo_release;
    spi_cs_n [*6] |-> !spi_sdo_oe;
  endproperty
  a_sdo_release: assert property (p_sdo_release) else $error("sdo driven while idle");
endmodule : strb_trim_bank_asserts

bind strb_trim_bank strb_trim_bank_asserts u_chk (.clk(clk), .rst(rst), .spi_cs_n(spi_cs_n),
  .spi_sdo_oe(spi_sdo_oe), .fuse_rd(fuse_rd), .fuse_addr(fuse_addr), .dual_mode(dual_mode),
  .fg_cal_en(fg_cal_en), .core_a_timing_trim(core_a_timing_trim),
  .core_b_timing_trim(core_b_timing_trim), .core_timing_trim_valid(core_timing_trim_valid),
  .core_a_offset_trim(core_a_offset_trim), .core_a_offset_trim_valid(core_a_offset_trim_valid),
  .trims_loaded(trims_loaded));

/* sim/strb_trim_bank_tb.sv */
// Self-checking bench for the trim bank: fuse load, serial access, mode gating.
// Assumes fuse words are served combinationally from the fuse index port.
`timescale 1ns/10ps
`define CMP(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module strb_trim_bank_tb;
  import strb_pkg::*;
  localparam int HP = 8;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic spi_sclk = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_sdi = 1'b0;
  logic dual_mode = 1'b1;
  logic sample_input_b = 1'b0;
  logic fg_cal_en = 1'b1;
  logic spi_sdo, fuse_rd, core_timing_trim_valid, core_a_offset_trim_valid, trims_loaded;
  logic spi_sdo_oe, oe_seen;
  logic [IDX_W-1:0] fuse_addr;
  logic [WORD_W-1:0] fuse_data;
  logic [TIMING_W-1:0] core_a_timing_trim, core_b_timing_trim;
  logic [OFFSET_W-1:0] core_a_offset_trim;
  logic [15:0] fuse_tab [8];
  logic [15:0] mdl [8];
  logic [15:0] exp_q [$];
  logic [15:0] got, ev;
  logic [14:0] addr_tab [8] = '{ADDR_TT_A_DUAL, ADDR_TT_B_DUAL, ADDR_TT_A_SIN_A,
    ADDR_TT_B_SIN_A, ADDR_TT_A_SIN_B, ADDR_TT_B_SIN_B, ADDR_OT_A_DUAL_A, ADDR_OT_A_DUAL_B};
  logic [31:0] seed = 32'h49;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_fuse = 0;
  event res_ev;
  // Fuse storage answers from the index it is shown
  assign fuse_data = fuse_tab[fuse_addr];
  strb_trim_bank uut (.clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .fuse_rd(fuse_rd),
    .fuse_addr(fuse_addr), .fuse_data(fuse_data), .dual_mode(dual_mode),
    .sample_input_b(sample_input_b), .fg_cal_en(fg_cal_en),
    .core_a_timing_trim(core_a_timing_trim), .core_b_timing_trim(core_b_timing_trim),
    .core_timing_trim_valid(core_timing_trim_valid), .core_a_offset_trim(core_a_offset_trim),
    .core_a_offset_trim_valid(core_a_offset_trim_valid), .trims_loaded(trims_loaded));
  // Clock
  initial begin
    forever #5 clk = ~clk;
  end
  // Xorshift source for trim patterns
  function logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : xs
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Note the expectation, then hand the result to the monitor
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    got = g;
    -> res_ev;
    tick(1);
  endtask : chk
  // One 24-bit frame; read bits taken just before each late rising edge
  task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                     output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, wd};
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = f[i];
      tick(HP);
      if (i < 8) q[i] = spi_sdo;
      if (i == 0) oe_seen = spi_sdo_oe;
      spi_sclk = 1'b1;
      tick(HP);
      spi_sclk = 1'b0;
    end
    tick(HP);
    spi_cs_n = 1'b1;
    tick(HP);
  endtask : spi
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
    chk(16'h0000, {15'h0000, oe_seen});
  endtask : wr
  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, q);
    chk({8'h00, e}, {8'h00, q});
    chk(16'h0001, {15'h0000, oe_seen});
    chk(16'h0000, {15'h0000, spi_sdo_oe});
  endtask : rd_chk
  task automatic do_reset();
    int n;
    rst = 1'b1;
    n_fuse = 0;
    tick(3);
    rst = 1'b0;
    n = 0;
    while (trims_loaded !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(16'h0001, {15'h0000, trims_loaded});
    chk(16'h0008, n_fuse[15:0]);
  endtask : do_reset
  // Read back every register, then step through all modes
  task automatic check_all();
    logic [7:0] ea, eb;
    for (int k = 0; k < 8; k++) begin
      rd_chk(addr_tab[k], mdl[k][7:0]);
      if (k > 5) rd_chk(addr_tab[k] + 15'h0001, mdl[k][15:8]);
    end
    for (int m = 0; m < 5; m++) begin
      dual_mode = (m < 2 || m == 4);
      sample_input_b = m[0];
      fg_cal_en = (m != 4);
      tick(2);
      ea = (m < 2) ? mdl[0][7:0] : (m < 4) ? mdl[2 * m - 2][7:0] : 8'h00;
      eb = (m < 2) ? mdl[1][7:0] : (m < 4) ? mdl[2 * m - 1][7:0] : 8'h00;
      chk({8'h00, ea}, {8'h00, core_a_timing_trim});
      chk({8'h00, eb}, {8'h00, core_b_timing_trim});
      chk((m < 2) ? {4'h0, mdl[6 + m][11:0]} : 16'h0000, {4'h0, core_a_offset_trim});
      chk({14'h0000, m < 2, m != 4},
          {14'h0000, core_a_offset_trim_valid, core_timing_trim_valid});
    end
  endtask : check_all
  task report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // Monitor: oldest expectation against each result
  initial forever begin
    @(res_ev);
    ev = exp_q.pop_front();
    `CMP(got, ev)
  end
  // Hang guard, and a tally of fuse read pulses per load
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fuse_rd === 1'b1) n_fuse <= n_fuse + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    for (int k = 0; k < 8; k++) fuse_tab[k] = xs();
    do_reset();
    mdl = fuse_tab;
    check_all();
    for (int k = 0; k < 8; k++) begin
      mdl[k] = xs() & 16'h0fff;
      wr(addr_tab[k], mdl[k][7:0]);
      if (k > 5) wr(addr_tab[k] + 15'h0001, mdl[k][15:8]);
    end
    check_all();
    wr(15'h0316, 8'h5a);
    rd_chk(15'h0316, 8'h00);
    do_reset();
    mdl = fuse_tab;
    check_all();
    report_and_stop();
  end
endmodule : strb_trim_bank_tb
